/* File: hdl/delay_timer_latch_bank.sv */
// eight drop-off timers, eight pick-up timers, eight set-dominant latches
// Operation
// RULE1: eight independent drop-off channels with own setting
// RULE2: drop-off output asserts at once on input
// RULE3: drop-off output holds until release delay elapses
// RULE4: drop-off delay 0..3600000 ms, 10 ms steps
// RULE5: eight independent pick-up channels with own setting
// RULE6: pick-up output asserts after input held delay
// RULE7: pick-up delay 0..3600000 ms, 10 ms steps
// RULE8: delay accurate to 1 percent or 20 ms
// RULE9: eight latches, set wins over reset
// RULE10: latch truth table: hold, clear, set
// RULE11: latch state kept in non-volatile store
// RULE12: per-latch clear from panel or tool
// RULE13: unconnected timer inputs read as false
// RULE14: pick-up drops at once, restarts from zero
// RULE15: drop-off input return cancels running release
`timescale 1ns/1ns
`include "delay_timer_latch_bank_defs.svh"
`default_nettype none
module delay_timer_latch_bank
    import delay_timer_latch_bank_pkg::*;
#(
    // cycles per 10 ms step, shorten in simulation
    parameter int STEP_CYCLES = `DTL_STEP_MS * `DTL_CLK_KHZ
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // register bus
    input  wire apb_req_t   apb_req,
    output var  apb_rsp_t   apb_rsp,
    // timer booleans from and to user logic
    input  wire logic [7:0] drop_in,
    input  wire logic [7:0] pick_in,
    output logic      [7:0] drop_out,
    output logic      [7:0] pick_out,
    // latch booleans
    input  wire logic [7:0] latch_set,
    input  wire logic [7:0] latch_reset,
    input  wire logic [7:0] panel_clear,
    output logic      [7:0] latch_out,
    // non-volatile latch image
    input  wire logic [7:0] nv_state,
    output logic      [7:0] nv_store
);

    localparam delay_steps_t SET_MAX = delay_steps_t'(`DTL_SET_MAX_STEPS);
    localparam logic [17:0] DIV_LAST = 18'(STEP_CYCLES - 1);

    // address compare, used all over the decoder
    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] b);
        addr_is = (a == b);
    endfunction

    // three-bit block compare for the two setting banks
    function automatic logic in_bank(input logic [7:0] a,
                                     input logic [7:0] base);
        in_bank = (a[7:5] == base[7:5]) && (a[1:0] == 2'b00);
    endfunction

    apb_rsp_t     rsp_q;                  // registered bus answer
    delay_steps_t drop_set_q [8];         // release delays
    delay_steps_t pick_set_q [8];         // assert delays
    delay_steps_t drop_cnt_q [8];         // release progress
    delay_steps_t pick_cnt_q [8];         // assert progress
    logic [7:0]   drop_q;                 // drop-off outputs
    logic [7:0]   pick_q;                 // pick-up outputs
    logic [7:0]   latch_q;                // latch outputs
    logic [15:0]  mask_q;                 // input connected flags
    logic         restore_q;              // nv image still to load
    logic [17:0]  div_q;                  // step divider
    logic         tick_q;                 // one-cycle 10 ms pulse

    // bus phase decode
    wire          acc      = apb_req.psel & apb_req.penable;
    wire          acc_new  = acc & ~rsp_q.pready;
    wire          wr_fire  = acc & rsp_q.pready & apb_req.pwrite;
    wire [7:0]    addr     = apb_req.paddr;
    wire [2:0]    ch       = addr[4:2];
    wire          hit_drop = in_bank(addr, `DTL_DROP_SET_BASE);
    wire          hit_pick = in_bank(addr, `DTL_PICK_SET_BASE);
    wire          hit_clr  = addr_is(addr, `DTL_LATCH_CLR);
    wire          hit_lst  = addr_is(addr, `DTL_LATCH_STATE);
    wire          hit_out  = addr_is(addr, `DTL_OUT_STATE);
    wire          hit_mask = addr_is(addr, `DTL_IN_MASK);
    wire          hit      = hit_drop | hit_pick | hit_clr |
                             hit_lst | hit_out | hit_mask;

    // writes beyond the top step are clamped, not wrapped
    wire          too_big  = apb_req.pwdata > 32'(SET_MAX);
    wire delay_steps_t wset = too_big ? SET_MAX : apb_req.pwdata[18:0]; // RULE4 RULE7

    // read selection; the clear register reads as zero
    wire [31:0]   rd_data  =
        hit_drop ? {13'h0000, drop_set_q[ch]} :
        hit_pick ? {13'h0000, pick_set_q[ch]} :
        hit_lst  ? {24'h00_0000, latch_q} :
        hit_out  ? {16'h0000, pick_q, drop_q} :
        hit_mask ? {16'h0000, mask_q} : 32'h0000_0000;

    // unmasked inputs; a bit left unwired is cleared by software
    wire [7:0]    drop_en  = drop_in & mask_q[7:0];   // RULE13
    wire [7:0]    pick_en  = pick_in & mask_q[15:8];  // RULE13

    // clear command from the tool write or the local panel
    wire [7:0]    clr_wr   = (wr_fire & hit_clr) ? apb_req.pwdata[7:0] : 8'h00;
    wire [7:0]    clr_all  = clr_wr | panel_clear;    // RULE12

    // latch next state: set wins over reset and over clear
    wire [7:0]    latch_d  = latch_set |
                             (latch_q & ~latch_reset & ~clr_all); // RULE9 RULE10

    assign apb_rsp   = rsp_q;
    assign drop_out  = drop_q;
    assign pick_out  = pick_q;
    assign latch_out = latch_q;
    assign nv_store  = latch_q;    // RULE11

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_q <= '0;
        end else begin
            rsp_q.pready  <= acc_new;
            rsp_q.pslverr <= acc_new & ~hit;
            rsp_q.prdata  <= (acc_new & ~apb_req.pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // input connect mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `DTL_MASK_RESET;
        end else if (wr_fire & hit_mask) begin
            mask_q <= apb_req.pwdata[15:0];
        end
    end

    // free-running step base; worst error one step, inside 20 ms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q  <= 18'h0_0000;
            tick_q <= 1'b0;
        end else begin
            div_q  <= (div_q == DIV_LAST) ? 18'h0_0000 : div_q + 18'h0_0001; // RULE8
            tick_q <= (div_q == DIV_LAST);                                  // RULE8
        end
    end

    // latches: reset shows zero, the first edge loads the nv image
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restore_q <= 1'b1;
            latch_q   <= `DTL_LATCH_RESET;
        end else if (restore_q) begin
            restore_q <= 1'b0;
            latch_q   <= nv_state;   // RULE11
        end else begin
            latch_q   <= latch_d;    // RULE9 RULE10 RULE12
        end
    end

    // one slice per channel, drop-off and pick-up side by side
    for (genvar i = 0; i < 8; i++) begin : g_ch
        wire drop_done = drop_cnt_q[i] >= drop_set_q[i];
        wire pick_done = pick_cnt_q[i] >= pick_set_q[i];
        wire drop_wr   = wr_fire & hit_drop & (ch == 3'(i));
        wire pick_wr   = wr_fire & hit_pick & (ch == 3'(i));

        // delay settings, one per channel
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                drop_set_q[i] <= `DTL_SET_RESET;
                pick_set_q[i] <= `DTL_SET_RESET;
            end else begin
                if (drop_wr) begin
                    drop_set_q[i] <= wset;   // RULE1 RULE4
                end
                if (pick_wr) begin
                    pick_set_q[i] <= wset;   // RULE5 RULE7
                end
            end
        end

        // drop-off: set by input, released once the count is done
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                drop_q[i]     <= 1'b0;
                drop_cnt_q[i] <= 19'h0_0000;
            end else if (drop_en[i] | ~drop_q[i]) begin
                drop_q[i]     <= drop_en[i];    // RULE2 RULE15
                drop_cnt_q[i] <= 19'h0_0000;    // RULE15
            end else if (drop_done) begin
                drop_q[i]     <= 1'b0;          // RULE3
            end else if (tick_q) begin
                drop_cnt_q[i] <= drop_cnt_q[i] + 19'h0_0001; // RULE3
            end
        end

        // pick-up: counts while input holds, zero on any drop
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pick_q[i]     <= 1'b0;
                pick_cnt_q[i] <= 19'h0_0000;
            end else if (!pick_en[i]) begin
                pick_q[i]     <= 1'b0;          // RULE14
                pick_cnt_q[i] <= 19'h0_0000;    // RULE14
            end else if (pick_done) begin
                pick_q[i]     <= 1'b1;          // RULE6
            end else if (tick_q) begin
                pick_cnt_q[i] <= pick_cnt_q[i] + 19'h0_0001; // RULE6
            end
        end

        // release in progress: input gone, output still high
        sequence drop_release;
            !drop_en[i] && drop_q[i] && !drop_done;
        endsequence

        drop_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
            drop_en[i] |=> drop_q[i])
            else $error("drop-off output not set by input");

        drop_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
            drop_release |=> drop_q[i])
            else $error("drop-off output released early");

        drop_end_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
            (!drop_en[i] && drop_q[i] && drop_done) |=> !drop_q[i])
            else $error("drop-off output held past its delay");

        drop_cancel_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
            (drop_release ##1 drop_en[i]) |=> (drop_q[i] && drop_cnt_q[i] == 19'h0_0000))
            else $error("running release not cancelled");

        pick_early_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
            $rose(pick_q[i]) |-> $past(pick_en[i]) && $past(pick_done))
            else $error("pick-up output set before delay");

        pick_fire_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
            (pick_en[i] && pick_done) |=> pick_q[i])
            else $error("pick-up output late");

        pick_drop_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
            !pick_en[i] |=> (!pick_q[i] && pick_cnt_q[i] == 19'h0_0000))
            else $error("pick-up not cleared on input drop");

        set_range_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4 RULE7
            drop_set_q[i] <= SET_MAX && pick_set_q[i] <= SET_MAX)
            else $error("delay setting above range");

        in_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
            (!mask_q[i + 8] && !pick_q[i]) |=> !pick_q[i])
            else $error("unconnected input acted as true");

        drop_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
            (!mask_q[i] && !drop_q[i]) |=> !drop_q[i])
            else $error("unconnected drop input acted as true");

        latch_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
            (latch_set[i] && !restore_q) |=> latch_q[i])
            else $error("latch set lost");

        latch_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10 RULE12
            (!latch_set[i] && (latch_reset[i] || clr_all[i]) && !restore_q)
            |=> !latch_q[i])
            else $error("latch not cleared");

        latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
            (!latch_set[i] && !latch_reset[i] && !clr_all[i] && !restore_q)
            |=> $stable(latch_q[i]))
            else $error("latch changed without cause");
    end

    // step pulse spacing: two pulses never come on back-to-back cycles
    tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        tick_q |=> !tick_q)
        else $error("step pulse too frequent");

    // sampled presetn skips the release edge, where restore_q still shows its reset value
    restore_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        (restore_q && presetn) |=> (latch_q == $past(nv_state) && !restore_q))
        else $error("nv image not restored");

    bus_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_new |=> rsp_q.pready ##1 !rsp_q.pready)
        else $error("bus answer not one cycle");

endmodule
`default_nettype wire

/* File: shared/delay_timer_latch_bank_defs.svh */
// constants for the delay timer and latch bank: offsets, resets, timing
`ifndef DELAY_TIMER_LATCH_BANK_DEFS_SVH
`define DELAY_TIMER_LATCH_BANK_DEFS_SVH
// register byte offsets
`define DTL_DROP_SET_BASE 8'h00
`define DTL_PICK_SET_BASE 8'h20
`define DTL_LATCH_CLR     8'h40
`define DTL_LATCH_STATE   8'h44
`define DTL_OUT_STATE     8'h48
`define DTL_IN_MASK       8'h4C
// field positions in the output status word
`define DTL_OUT_DROP_LSB  0
`define DTL_OUT_PICK_LSB  8
// reset values
`define DTL_SET_RESET     19'h0_0000
`define DTL_MASK_RESET    16'hFFFF
`define DTL_LATCH_RESET   8'h00
// timing: clock rate in kHz, delay step and longest delay in ms
`define DTL_CLK_KHZ       25000
`define DTL_STEP_MS       10
`define DTL_SET_MAX_MS    3600000
`define DTL_SET_MAX_STEPS (`DTL_SET_MAX_MS / `DTL_STEP_MS)
`endif

/* File: shared/delay_timer_latch_bank_pkg.sv */
// types shared by the delay timer and latch bank
`default_nettype none
package delay_timer_latch_bank_pkg;
    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    // apb answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
    // one delay setting in 10 ms steps
    typedef logic [18:0] delay_steps_t;
endpackage
`default_nettype wire

/* File: verif/user_logic_model.sv */
// far-side user logic model driving the bank's timer and latch booleans
`timescale 1ns/1ns
`default_nettype none
module user_logic_model (
    // clock
    input  wire logic pclk,
    // booleans toward the bank
    output logic [7:0] drop_in,
    output logic [7:0] pick_in,
    output logic [7:0] latch_set,
    output logic [7:0] latch_reset,
    output logic [7:0] panel_clear
);
    // unused sources drive false rather than float
    initial begin
        drop_in     = 8'h00;
        pick_in     = 8'h00;
        latch_set   = 8'h00;
        latch_reset = 8'h00;
        panel_clear = 8'h00;
    end
    // all groups change together just after one rising edge
    task automatic put(input logic [7:0] d, p, s, r, c);
        @(posedge pclk);
        drop_in     <= d;
        pick_in     <= p;
        latch_set   <= s;
        latch_reset <= r;
        panel_clear <= c;
    endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the delay timer and latch bank
`timescale 1ns/1ns
`include "delay_timer_latch_bank_defs.svh"
`default_nettype none
module tb
    import delay_timer_latch_bank_pkg::*;
;
    localparam int STEP = 4; // short step keeps the run brief
    logic        pclk       = 1'b0;
    logic        presetn    = 1'b0;
    apb_req_t    req        = '0;
    apb_rsp_t    rsp;
    logic [7:0]  d_in, p_in, d_out, p_out, l_set, l_rst, p_clr, l_out, nv_out;
    logic [7:0]  nv_in      = 8'hA5;
    logic [7:0]  lq         = 8'hA5; // latch model
    logic [31:0] rnd        = 32'h0000_0061;
    logic [32:0] exp_q[$];           // expected {pslverr, prdata}
    int          error_cnt  = 0;
    int          n_compared = 0;

    // free-running bus clock
    always #20 pclk = ~pclk;

    delay_timer_latch_bank #(.STEP_CYCLES(STEP)) dut_u (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .drop_in(d_in), .pick_in(p_in), .drop_out(d_out), .pick_out(p_out),
        .latch_set(l_set), .latch_reset(l_rst), .panel_clear(p_clr),
        .latch_out(l_out), .nv_state(nv_in), .nv_store(nv_out));
    user_logic_model p_u (.pclk(pclk), .drop_in(d_in), .pick_in(p_in),
        .latch_set(l_set), .latch_reset(l_rst), .panel_clear(p_clr));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic chk(input logic [32:0] s, e, input string nm);
        n_compared++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, s);
            error_cnt++;
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // wait n edges, then step past the edge's updates
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // one apb transfer; reads note their expected answer first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int k;
        if (!w) exp_q.push_back(e);
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        if (k >= 20) error_cnt++; // a lost answer counts as a mismatch
        req <= '0;
    endtask

    // read answers taken at the edge where pready is sampled
    always @(posedge pclk) begin
        if (presetn && rsp.pready === 1'b1 && req.pwrite === 1'b0 && exp_q.size() > 0)
            chk({rsp.pslverr, rsp.prdata}, exp_q.pop_front(), "apb read");
    end

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2);
        chk(l_out, lq, "restore");
        apb(0, 8'h00, 0, 33'h0);
        apb(0, `DTL_IN_MASK, 0, 33'h0_0000_FFFF);
        apb(0, 8'h50, 0, 33'h1_0000_0000);
        apb(1, 8'h3C, 32'h0006_1A80, 0);
        apb(0, 8'h3C, 0, 33'h0_0005_7E40);
        apb(1, 8'h0C, 32'h0000_0003, 0);
        apb(1, 8'h34, 32'h0000_0003, 0);
        apb(0, 8'h0C, 0, 33'h0_0000_0003);
        $display("test registers done");
        // drop-off: ch1 zero delay, ch3 three steps
        p_u.put(8'h0A, 0, 0, 0, 0);
        cyc(1);
        chk(d_out, 8'h0A, "drop rise");
        p_u.put(8'h00, 0, 0, 0, 0);
        cyc(3);
        chk(d_out, 8'h08, "drop hold");
        cyc(3);
        p_u.put(8'h08, 0, 0, 0, 0);
        cyc(12);
        chk(d_out, 8'h08, "drop cancel");
        p_u.put(8'h00, 0, 0, 0, 0);
        cyc(6);
        chk(d_out, 8'h08, "drop late");
        cyc(10);
        chk(d_out, 8'h00, "drop fall");
        $display("test drop-off done");
        // pick-up: ch5 three steps, ch6 zero delay
        p_u.put(0, 8'h60, 0, 0, 0);
        cyc(6);
        chk(p_out, 8'h40, "pick early");
        cyc(10);
        chk(p_out, 8'h60, "pick on");
        p_u.put(0, 8'h00, 0, 0, 0);
        cyc(1);
        chk(p_out, 8'h00, "pick drop");
        p_u.put(0, 8'h20, 0, 0, 0);
        cyc(6);
        p_u.put(0, 8'h00, 0, 0, 0);
        p_u.put(0, 8'h20, 0, 0, 0);
        cyc(6);
        chk(p_out, 8'h00, "pick restart");
        p_u.put(0, 8'h00, 0, 0, 0);
        $display("test pick-up done");
        // a masked input reads as false
        apb(1, `DTL_IN_MASK, 32'h0000_FEFE, 0);
        p_u.put(8'h01, 8'h01, 0, 0, 0);
        cyc(3);
        chk(d_out, 8'h00, "masked");
        chk(p_out, 8'h00, "pick masked");
        apb(1, `DTL_IN_MASK, 32'h0000_FFFF, 0);
        apb(0, `DTL_OUT_STATE, 0, 33'h0_0000_0101);
        p_u.put(8'h00, 8'h00, 0, 0, 0);
        $display("test mask done");
        // random set and reset patterns against the latch model
        for (int i = 0; i < 24; i++) begin
            rnd = xs(rnd);
            p_u.put(0, 0, rnd[7:0] & rnd[15:8], rnd[23:16], 0);
            cyc(1);
            lq = (rnd[7:0] & rnd[15:8]) | (lq & ~rnd[23:16]);
            chk(l_out, lq, "latch");
            chk(nv_out, lq, "store");
        end
        p_u.put(0, 0, 8'hFF, 8'hFF, 0);
        cyc(1);
        chk(l_out, 8'hFF, "set wins");
        p_u.put(0, 0, 8'h01, 0, 8'h0F);
        cyc(1);
        chk(l_out, 8'hF1, "panel clear");
        p_u.put(0, 0, 0, 0, 0);
        apb(1, `DTL_LATCH_CLR, 32'h0000_0030, 0);
        lq = 8'hC1;
        apb(0, `DTL_LATCH_STATE, 0, {25'h0, lq});
        $display("test latch done");
        // restart restores the stored image, timers back to default
        @(posedge pclk);
        nv_in   <= lq;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2);
        chk(l_out, lq, "restart");
        apb(0, 8'h0C, 0, 33'h0);
        $display("test restart done");
        print_verdict();
    end
endmodule
`default_nettype wire
